// >>> rtl/mtd_map.svh
// Register offsets, field positions and reset values of the magnetic threshold detector
`ifndef MTD_MAP_SVH
`define MTD_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MTD_ADDR_CFG        8'h52
`define MTD_ADDR_SRC        8'h53
`define MTD_ADDR_THS_X_HI   8'h54
`define MTD_ADDR_THS_X_LO   8'h55
`define MTD_ADDR_THS_Y_HI   8'h56
`define MTD_ADDR_THS_Y_LO   8'h57
`define MTD_ADDR_THS_Z_HI   8'h58
`define MTD_ADDR_THS_Z_LO   8'h59
`define MTD_ADDR_DB_COUNT   8'h5a

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define MTD_CFG_LATCH_EN    7
`define MTD_CFG_ANY_MODE    6
`define MTD_CFG_Z_EN        5
`define MTD_CFG_Y_EN        4
`define MTD_CFG_X_EN        3
`define MTD_CFG_WAKE_EN     2
`define MTD_CFG_INT_EN      1
`define MTD_CFG_INT_ROUTE   0

// ----------------------------------------------------------------
// Source register and threshold upper byte fields
// ----------------------------------------------------------------
`define MTD_SRC_ACTIVE      7
`define MTD_SRC_RESERVED    6
`define MTD_DB_MODE_BIT     7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MTD_RST_CFG         8'h00
`define MTD_RST_SRC         8'h00
`define MTD_RST_THS         15'h0000
`define MTD_RST_DB_COUNT    8'h00

`endif

// >>> rtl/mtd_pkg.sv
// Types shared by the magnetic threshold detector files
`default_nettype none
package mtd_pkg;
    typedef logic        [7:0]  mtd_byte_t;
    typedef logic signed [15:0] mtd_sample_t;
    typedef logic        [14:0] mtd_thresh_t;
endpackage
`default_nettype wire

// >>> rtl/mtd_axis_cmp.sv
// One axis: magnitude of a signed sample compared with an unsigned threshold
`timescale 1ns/100ps
`default_nettype none
module mtd_axis_cmp #(
    parameter int SAMPLE_W = 16,
    parameter int THRESH_W = 15
) (
    // Sample and threshold
    input  wire logic signed [SAMPLE_W-1:0] sample,
    input  wire logic        [THRESH_W-1:0] threshold,
    // Control
    input  wire logic                       enable,
    input  wire logic                       anyMode,
    // Result
    output logic                            axisHit,
    output logic                            negative
);
    logic [SAMPLE_W-1:0] magnitude;
    logic [SAMPLE_W-1:0] thrWide;

    // The most negative sample still gives the right unsigned magnitude
    always_comb begin
        magnitude = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : SAMPLE_W'(sample);
        thrWide   = SAMPLE_W'(threshold);
        negative  = sample[SAMPLE_W-1];
        if (!enable) begin
            axisHit = 1'b0;
        end else if (anyMode) begin
            axisHit = (magnitude >= thrWide);
        end else begin
            axisHit = (magnitude <= thrWide);
        end
    end
endmodule
`default_nettype wire

// >>> rtl/mtd_threshold_detector.sv
// Magnetic threshold event detector with its register file
//
// Operation
// - Compare thresholds against samples before offset correction.
// - Source shows live event, or latched since read.
// - Active bit seven equals configured axis combination.
// - Z high-event flag at bit five.
// - Z polarity bit four: one means negative.
// - Y flags at bits three and two.
// - X flags at bits one and zero.
// - Disabled axis reads zero flag and polarity.
// - Thresholds are fifteen-bit unsigned, 0.1 uT steps.
// - Thresholds at 0x54-0x59, upper bits low seven.
// - X upper bit seven selects debounce mode.
// - Mode one clears counter when condition false.
// - Mode zero decrements counter when condition false.
// - Source read-only, resets to zero.
// - Mode zero all below-or-equal; one any above-or-equal.
// - Unlatched flags track; latched hold until read.
// - Condition must persist the programmed sample count.
// - Enabled event routed to pin one or two.
`include "mtd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module mtd_threshold_detector #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            resetn,
    // Register port
    input  wire mtd_pkg::mtd_byte_t   regAddr,
    input  wire logic                 regWrite,
    input  wire mtd_pkg::mtd_byte_t   regWriteData,
    input  wire logic                 regRead,
    output mtd_pkg::mtd_byte_t        regReadData,
    // Uncorrected magnetometer samples
    input  wire logic                 sampleValid,
    input  wire mtd_pkg::mtd_sample_t rawSampleX,
    input  wire mtd_pkg::mtd_sample_t rawSampleY,
    input  wire mtd_pkg::mtd_sample_t rawSampleZ,
    // Event outputs
    output logic                      interruptPinOne,
    output logic                      interruptPinTwo,
    output logic                      wakeEvent
);
    import mtd_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    mtd_byte_t   cfg_q, cfg_d;
    mtd_thresh_t thr_q [3];
    mtd_thresh_t thr_d [3];
    logic        dbMode_q, dbMode_d;
    logic [CNT_W-1:0] dbCount_q, dbCount_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    mtd_byte_t   src_q, src_d;
    mtd_byte_t   rdata_q, rdata_d;

    logic        srcReadNow;
    logic [2:0]  axisEnable;
    logic [2:0]  axisHit;
    logic [2:0]  axisNeg;
    logic        condition;
    logic        fire;
    mtd_byte_t   newSrc;
    mtd_byte_t   srcView;
    mtd_sample_t samples [3];

    assign samples[0] = rawSampleX;
    assign samples[1] = rawSampleY;
    assign samples[2] = rawSampleZ;
    assign axisEnable = {cfg_q[`MTD_CFG_Z_EN], cfg_q[`MTD_CFG_Y_EN], cfg_q[`MTD_CFG_X_EN]};
    assign srcReadNow = regRead && (regAddr == `MTD_ADDR_SRC);

    // ----------------------------------------------------------------
    // Per-axis comparison
    // ----------------------------------------------------------------
    // Samples arrive before offset correction, so no offset is applied here
    for (genvar i = 0; i < 3; i++) begin : gAxis
        mtd_axis_cmp #(
            .SAMPLE_W (16),
            .THRESH_W (15)
        ) uCmp (
            .sample    (samples[i]),
            .threshold (thr_q[i]),
            .enable    (axisEnable[i]),
            .anyMode   (cfg_q[`MTD_CFG_ANY_MODE]),
            .axisHit   (axisHit[i]),
            .negative  (axisNeg[i])
        );
        assign newSrc[2*i+1] = fire & axisHit[i];
        assign newSrc[2*i]   = fire & axisHit[i] & axisNeg[i];
    end
    assign newSrc[`MTD_SRC_ACTIVE]   = fire;
    assign newSrc[`MTD_SRC_RESERVED] = 1'b0;

    // ----------------------------------------------------------------
    // Combined condition and debounce
    // ----------------------------------------------------------------
    always_comb begin
        if (cfg_q[`MTD_CFG_ANY_MODE]) begin
            condition = |axisHit;
        end else begin
            // An all-disabled AND would be vacuously true; treat it as no event
            condition = (|axisEnable) && (&(axisHit | ~axisEnable));
        end
        cnt_d = cnt_q;
        if (sampleValid) begin
            if (condition) begin
                if (cnt_q < dbCount_q) begin
                    cnt_d = cnt_q + 1'b1;
                end
            end else if (dbMode_q) begin
                cnt_d = '0;
            end else if (cnt_q != '0) begin
                cnt_d = cnt_q - 1'b1;
            end
        end
        fire = sampleValid && condition && (cnt_d >= dbCount_q);
    end

    // ----------------------------------------------------------------
    // Source register
    // ----------------------------------------------------------------
    always_comb begin
        src_d = src_q;
        if (cfg_q[`MTD_CFG_LATCH_EN]) begin
            // A new event in the clearing cycle survives the read
            if (srcReadNow) begin
                src_d = '0;
            end
            if (sampleValid) begin
                src_d = src_d | newSrc;
            end
        end else if (sampleValid) begin
            src_d = newSrc;
        end
        srcView = src_q & {1'b1, 1'b0, {2{axisEnable[2]}}, {2{axisEnable[1]}},
                           {2{axisEnable[0]}}};
    end

    // ----------------------------------------------------------------
    // Register writes and reads
    // ----------------------------------------------------------------
    always_comb begin
        cfg_d     = cfg_q;
        thr_d     = thr_q;
        dbMode_d  = dbMode_q;
        dbCount_d = dbCount_q;
        rdata_d   = rdata_q;
        if (regWrite) begin
            // Writes to the source register fall through: it is read-only
            unique case (regAddr)
                `MTD_ADDR_CFG: cfg_d = regWriteData;
                `MTD_ADDR_THS_X_HI: begin
                    dbMode_d = regWriteData[`MTD_DB_MODE_BIT];
                    thr_d[0] = {regWriteData[6:0], thr_q[0][7:0]};
                end
                `MTD_ADDR_THS_X_LO: thr_d[0] = {thr_q[0][14:8], regWriteData};
                `MTD_ADDR_THS_Y_HI: thr_d[1] = {regWriteData[6:0], thr_q[1][7:0]};
                `MTD_ADDR_THS_Y_LO: thr_d[1] = {thr_q[1][14:8], regWriteData};
                `MTD_ADDR_THS_Z_HI: thr_d[2] = {regWriteData[6:0], thr_q[2][7:0]};
                `MTD_ADDR_THS_Z_LO: thr_d[2] = {thr_q[2][14:8], regWriteData};
                `MTD_ADDR_DB_COUNT: dbCount_d = CNT_W'(regWriteData);
                default: ;
            endcase
        end
        if (regRead) begin
            // One registered capture of the whole byte keeps the snapshot coherent
            unique case (regAddr)
                `MTD_ADDR_CFG:      rdata_d = cfg_q;
                `MTD_ADDR_SRC:      rdata_d = srcView;
                `MTD_ADDR_THS_X_HI: rdata_d = {dbMode_q, thr_q[0][14:8]};
                `MTD_ADDR_THS_X_LO: rdata_d = thr_q[0][7:0];
                `MTD_ADDR_THS_Y_HI: rdata_d = {1'b0, thr_q[1][14:8]};
                `MTD_ADDR_THS_Y_LO: rdata_d = thr_q[1][7:0];
                `MTD_ADDR_THS_Z_HI: rdata_d = {1'b0, thr_q[2][14:8]};
                `MTD_ADDR_THS_Z_LO: rdata_d = thr_q[2][7:0];
                `MTD_ADDR_DB_COUNT: rdata_d = 8'(dbCount_q);
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            cfg_q     <= `MTD_RST_CFG;
            thr_q     <= '{default: `MTD_RST_THS};
            dbMode_q  <= 1'b0;
            dbCount_q <= CNT_W'(`MTD_RST_DB_COUNT);
            cnt_q     <= '0;
            src_q     <= `MTD_RST_SRC;
            rdata_q   <= 8'h00;
        end else begin
            cfg_q     <= cfg_d;
            thr_q     <= thr_d;
            dbMode_q  <= dbMode_d;
            dbCount_q <= dbCount_d;
            cnt_q     <= cnt_d;
            src_q     <= src_d;
            rdata_q   <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Only this event feeds the pins here; other sources would be ORed outside
    assign regReadData     = rdata_q;
    assign interruptPinOne = cfg_q[`MTD_CFG_INT_EN] & cfg_q[`MTD_CFG_INT_ROUTE]
                             & src_q[`MTD_SRC_ACTIVE];
    assign interruptPinTwo = cfg_q[`MTD_CFG_INT_EN] & ~cfg_q[`MTD_CFG_INT_ROUTE]
                             & src_q[`MTD_SRC_ACTIVE];
    assign wakeEvent       = cfg_q[`MTD_CFG_WAKE_EN] & src_q[`MTD_SRC_ACTIVE];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_active_on_fire: assert property (@(posedge clock) disable iff (!resetn)
        fire |=> src_q[`MTD_SRC_ACTIVE])
        else $error("active flag not set after event");

    a_live_clears: assert property (@(posedge clock) disable iff (!resetn)
        (sampleValid && !fire && !cfg_q[`MTD_CFG_LATCH_EN]) |=> (src_q == 8'h00))
        else $error("unlatched source did not clear");

    a_latch_holds: assert property (@(posedge clock) disable iff (!resetn)
        (cfg_q[`MTD_CFG_LATCH_EN] && src_q[`MTD_SRC_ACTIVE] && !srcReadNow
         && !(regWrite && regAddr == `MTD_ADDR_CFG)) |=> src_q[`MTD_SRC_ACTIVE])
        else $error("latched event lost without a read");

    a_mask_x_axis: assert property (@(posedge clock) disable iff (!resetn)
        (srcReadNow && !axisEnable[0]) |=> (regReadData[1:0] == 2'b00))
        else $error("disabled X axis flags read nonzero");

    a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
        srcReadNow |=> (regReadData[`MTD_SRC_RESERVED] == 1'b0))
        else $error("reserved source bit read nonzero");

    a_db_clear: assert property (@(posedge clock) disable iff (!resetn)
        (sampleValid && !condition && dbMode_q) |=> (cnt_q == '0))
        else $error("debounce counter not cleared");

    a_db_decrement: assert property (@(posedge clock) disable iff (!resetn)
        (sampleValid && !condition && !dbMode_q && cnt_q != '0)
        |=> (cnt_q == $past(cnt_q) - 1'b1))
        else $error("debounce counter not decremented");

    a_db_saturate: assert property (@(posedge clock) disable iff (!resetn)
        (sampleValid && condition && !(regWrite && regAddr == `MTD_ADDR_DB_COUNT))
        |=> (cnt_q == (($past(cnt_q) < dbCount_q) ? $past(cnt_q) + 1'b1 : $past(cnt_q))))
        else $error("debounce counter step wrong");

    a_pin_route: assert property (@(posedge clock) disable iff (!resetn)
        (src_q[`MTD_SRC_ACTIVE] && cfg_q[`MTD_CFG_INT_EN])
        |-> (interruptPinOne == cfg_q[`MTD_CFG_INT_ROUTE]) && (interruptPinTwo != interruptPinOne))
        else $error("event routed to wrong pin");

    a_src_reset: assert property (@(posedge clock)
        !resetn |=> (src_q == 8'h00))
        else $error("source register not zero after reset");

    a_mask_y_axis: assert property (@(posedge clock) disable iff (!resetn)
        (srcReadNow && !axisEnable[1]) |=> (regReadData[3:2] == 2'b00))
        else $error("disabled Y axis flags read nonzero");

    a_mask_z_axis: assert property (@(posedge clock) disable iff (!resetn)
        (srcReadNow && !axisEnable[2]) |=> (regReadData[5:4] == 2'b00))
        else $error("disabled Z axis flags read nonzero");

    // A write aimed at the source must leave it alone when nothing else moves it
    a_src_read_only: assert property (@(posedge clock) disable iff (!resetn)
        (regWrite && regAddr == `MTD_ADDR_SRC && !sampleValid && !srcReadNow)
        |=> (src_q == $past(src_q)))
        else $error("source register changed by a write");

    a_and_none_enabled: assert property (@(posedge clock) disable iff (!resetn)
        (!cfg_q[`MTD_CFG_ANY_MODE] && axisEnable == 3'b000) |-> !condition)
        else $error("AND of no enabled axis raised the condition");

    a_no_early_fire: assert property (@(posedge clock) disable iff (!resetn)
        (dbCount_q > cnt_q && (dbCount_q - cnt_q) > CNT_W'(1)) |-> !fire)
        else $error("event fired before the debounce count");

    a_z_flag_set: assert property (@(posedge clock) disable iff (!resetn)
        (fire && axisHit[2]) |=> src_q[5])
        else $error("Z high-event flag not set");

    a_z_polarity: assert property (@(posedge clock) disable iff (!resetn)
        (fire && axisHit[2] && !cfg_q[`MTD_CFG_LATCH_EN])
        |=> (src_q[4] == $past(rawSampleZ[15])))
        else $error("Z polarity flag wrong");

    a_pins_quiet: assert property (@(posedge clock) disable iff (!resetn)
        !cfg_q[`MTD_CFG_INT_EN] |-> (!interruptPinOne && !interruptPinTwo))
        else $error("interrupt pin driven while disabled");

    // Read data stands between reads so a slow host still sees its byte
    a_rdata_holds: assert property (@(posedge clock) disable iff (!resetn)
        !regRead |=> $stable(regReadData))
        else $error("read data changed without a read");
endmodule
`default_nettype wire

// >>> verif/mtd_host.sv
// Host microcontroller model that drives the register port
`timescale 1ns/100ps
`default_nettype none
module mtd_host (
    // Clock
    input  wire logic               clock,
    // Register port
    output mtd_pkg::mtd_byte_t      regAddr,
    output logic                    regWrite,
    output mtd_pkg::mtd_byte_t      regWriteData,
    output logic                    regRead,
    input  wire mtd_pkg::mtd_byte_t regReadData
);
    import mtd_pkg::*;

    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWriteData = 8'h00;
        regRead = 1'b0;
    end

    // Released address and data lines flip so a stale value can never pass for a fresh one
    task automatic releaseBus();
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = ~regAddr;
        regWriteData = ~regWriteData;
    endtask

    task automatic writeReg(input mtd_byte_t addr, input mtd_byte_t data);
        @(posedge clock);
        #1;
        regAddr = addr;
        regWriteData = data;
        regWrite = 1'b1;
        @(posedge clock);
        #1;
        releaseBus();
    endtask

    // Read data is registered at the strobe edge, so it is settled just after it
    task automatic readReg(input mtd_byte_t addr, output mtd_byte_t data);
        @(posedge clock);
        #1;
        regAddr = addr;
        regRead = 1'b1;
        @(posedge clock);
        #1;
        data = regReadData;
        releaseBus();
    endtask
endmodule
`default_nettype wire

// >>> verif/magnetic_threshold_detector_tb.sv
// Self-checking testbench of the magnetic threshold detector
`timescale 1ns/100ps
`default_nettype none
module magnetic_threshold_detector_tb;
    import mtd_pkg::*;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        sampleValid = 1'b0;
    mtd_sample_t sx = '0;
    mtd_sample_t sy = '0;
    mtd_sample_t sz = '0;
    mtd_byte_t   regAddr, regWriteData, regReadData, rd;
    logic        regWrite, regRead, pinOne, pinTwo, wake;
    int          numErrors = 0;
    int          testsRun = 0;

    always #20 clock = ~clock;

    mtd_threshold_detector #(.CNT_W(8)) dut (
        .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
        .sampleValid(sampleValid), .rawSampleX(sx), .rawSampleY(sy), .rawSampleZ(sz),
        .interruptPinOne(pinOne), .interruptPinTwo(pinTwo), .wakeEvent(wake));

    mtd_host host (
        .clock(clock), .regAddr(regAddr), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData));

    task automatic check(input string what, input mtd_byte_t seen, input mtd_byte_t exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stopTest();
        if (numErrors == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic sample(input mtd_sample_t x, input mtd_sample_t y, input mtd_sample_t z);
        @(posedge clock);
        #1;
        sx = x;
        sy = y;
        sz = z;
        sampleValid = 1'b1;
        @(posedge clock);
        #1;
        sampleValid = 1'b0;
        sx = ~x;
        sy = ~y;
        sz = ~z;
    endtask

    task automatic readCheck(input string what, input mtd_byte_t addr, input mtd_byte_t exp);
        host.readReg(addr, rd);
        check(what, rd, exp);
    endtask

    task automatic setThr(input mtd_byte_t hi, input logic mode, input mtd_thresh_t t);
        host.writeReg(hi, {mode, t[14:8]});
        host.writeReg(hi + 8'h01, t[7:0]);
    endtask

    task automatic pins(input logic one, input logic two, input logic wk);
        check("pins", {5'h00, pinOne, pinTwo, wake}, {5'h00, one, two, wk});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic testReset();
        readCheck("src", 8'h53, 8'h00);
        readCheck("xhi", 8'h54, 8'h00);
        readCheck("unmapped", 8'h30, 8'h00);
        host.writeReg(8'h53, 8'hff);
        readCheck("src ro", 8'h53, 8'h00);
        setThr(8'h54, 1'b1, 15'h7fff);
        readCheck("xhi mode", 8'h54, 8'hff);
        host.writeReg(8'h56, 8'hff);
        readCheck("yhi", 8'h56, 8'h7f);
    endtask

    task automatic testOrMode();
        host.writeReg(8'h52, 8'h7f);
        host.writeReg(8'h5a, 8'h00);
        setThr(8'h54, 1'b0, 15'd100);
        setThr(8'h56, 1'b0, 15'd100);
        setThr(8'h58, 1'b0, 15'd100);
        sample(-16'sd200, 16'sd150, -16'sd300);
        readCheck("or all", 8'h53, 8'hbb);
        pins(1'b1, 1'b0, 1'b1);
        // Z disabled after its flags were stored: masked only at read
        host.writeReg(8'h52, 8'h5f);
        readCheck("cfg", 8'h52, 8'h5f);
        readCheck("mask read", 8'h53, 8'h8b);
        host.writeReg(8'h52, 8'h7f);
        sample(16'sd100, -16'sd99, 16'sd0);
        readCheck("or equal", 8'h53, 8'h82);
        sample(16'sd50, -16'sd99, 16'sd0);
        readCheck("or none", 8'h53, 8'h00);
        pins(1'b0, 1'b0, 1'b0);
        // Z disabled, routed to pin two
        host.writeReg(8'h52, 8'h5a);
        sample(16'sd200, 16'sd0, -16'sd300);
        readCheck("mask z", 8'h53, 8'h82);
        pins(1'b0, 1'b1, 1'b0);
    endtask

    task automatic testAndMode();
        host.writeReg(8'h52, 8'h0a);
        sample(-16'sd100, 16'sd5000, 16'sd5000);
        readCheck("and hit", 8'h53, 8'h83);
        host.writeReg(8'h52, 8'h02);
        sample(16'sd0, 16'sd0, 16'sd0);
        readCheck("and none", 8'h53, 8'h00);
        host.writeReg(8'h52, 8'h0a);
        sample(-16'sd101, 16'sd0, 16'sd0);
        readCheck("and miss", 8'h53, 8'h00);
    endtask

    // True, true, false, true, true: only a decrementing counter reaches three
    task automatic testDebounce(input logic mode);
        host.writeReg(8'h52, 8'h4a);
        host.writeReg(8'h5a, 8'h03);
        readCheck("db count", 8'h5a, 8'h03);
        setThr(8'h54, mode, 15'd100);
        repeat (3) sample(16'sd0, 16'sd0, 16'sd0);
        sample(16'sd200, 16'sd0, 16'sd0);
        sample(16'sd200, 16'sd0, 16'sd0);
        readCheck("db early", 8'h53, 8'h00);
        sample(16'sd0, 16'sd0, 16'sd0);
        sample(16'sd200, 16'sd0, 16'sd0);
        sample(16'sd200, 16'sd0, 16'sd0);
        readCheck("db mode", 8'h53, mode ? 8'h00 : 8'h82);
        sample(16'sd200, 16'sd0, 16'sd0);
        readCheck("db sat", 8'h53, 8'h82);
    endtask

    task automatic testLatch();
        host.writeReg(8'h52, 8'hca);
        host.writeReg(8'h5a, 8'h00);
        sample(-16'sd200, 16'sd0, 16'sd0);
        sample(16'sd0, 16'sd0, 16'sd0);
        readCheck("latched", 8'h53, 8'h83);
        readCheck("cleared", 8'h53, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        #1;
        resetn = 1'b1;
        testReset();
        testOrMode();
        testAndMode();
        testDebounce(1'b1);
        testDebounce(1'b0);
        testLatch();
        stopTest();
    end

    initial begin
        repeat (5000) @(posedge clock);
        numErrors++;
        stopTest();
    end
endmodule
`default_nettype wire
